// *** logic/sbi_burst_ctl.sv ***
// burst engine: cross-bank interrupt of read and write bursts
`timescale 1ns/1ps
`default_nettype none
`include "sbi_cfg.svh"
module sbi_burst_ctl
  import sbi_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`SBI_BA_W-1:0] ba,
  input wire logic [`SBI_ADDR_W-1:0] addr,
  input wire logic [`SBI_DM_W-1:0] dqm,
  input wire logic [`SBI_DQ_W-1:0] dq_i,
  input wire logic [`SBI_DQ_W-1:0] rd_data,
  output logic [`SBI_DQ_W-1:0] dq_o,
  output logic [`SBI_DM_W-1:0] dq_oe,
  output logic wr_valid,
  output logic [`SBI_BA_W-1:0] wr_bank,
  output logic [`SBI_COL_W-1:0] wr_col,
  output logic [`SBI_DQ_W-1:0] wr_data,
  output logic [`SBI_DM_W-1:0] wr_mask,
  output logic rd_req,
  output logic [`SBI_BA_W-1:0] rd_bank,
  output logic [`SBI_COL_W-1:0] rd_col,
  output logic [`SBI_BANKS-1:0] pre_start,
  output logic [`SBI_BANKS-1:0] bank_busy
);

  ////////////////////////////////////////////////////////////////////////
  // state and synchronised pin view
  sbi_state_t q; // registered state
  sbi_state_t d; // next state
  logic s_clk; // synced link clock
  logic s_cs_n; // synced chip select
  logic s_ras_n; // synced row strobe
  logic s_cas_n; // synced column strobe
  logic s_we_n; // synced write enable
  logic [`SBI_BA_W-1:0] s_ba; // synced bank
  logic [`SBI_ADDR_W-1:0] s_addr; // synced address
  logic [`SBI_DM_W-1:0] s_dqm; // synced data mask
  logic [`SBI_DQ_W-1:0] s_dq; // synced write data

  // only the second stage is read; first stage feeds it alone
  assign {s_clk, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr, s_dqm, s_dq} = q.pin_s2;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic edge_hit; // rising link clock seen
    logic is_rd; // read command
    logic is_wr; // write command
    logic is_pre; // precharge command
    logic [`SBI_BANKS-1:0] pre_go; // start precharge now
    logic [`SBI_BANKS-1:0] wr_go; // start write recovery
    logic [`SBI_BANKS-1:0] busy_set; // new access marks bank busy
    edge_hit = 1'b0;
    busy_set = '0;
    is_rd = 1'b0;
    is_wr = 1'b0;
    is_pre = 1'b0;
    pre_go = '0;
    wr_go = '0;
    d = q;
    d.pin_s1 = {link_clk, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_i};
    d.pin_s2 = q.pin_s1;
    d.lclk_prev = s_clk;
    d.pre_start = '0;
    d.wr_valid = 1'b0;
    d.rd_req = 1'b0;
    // array answers one cycle after a read request
    d.rd_pend = q.rd_req;
    if (q.rd_pend)
    begin
      d.stage = rd_data;
      d.stage_v = 1'b1;
    end
    edge_hit = s_clk & ~q.lclk_prev;
    if (edge_hit)
    begin
      is_rd = ~s_cs_n & s_ras_n & ~s_cas_n & s_we_n;
      is_wr = ~s_cs_n & s_ras_n & ~s_cas_n & ~s_we_n;
      is_pre = ~s_cs_n & ~s_ras_n & s_cas_n & ~s_we_n;
      // read data pipeline advances one link clock
      for (int i = `SBI_CAS_LAT - 1; i > 0; i--)
      begin
        d.pipe[i] = q.pipe[i-1];
        d.pipe_v[i] = q.pipe_v[i-1];
      end
      d.pipe[0] = q.stage;
      d.pipe_v[0] = q.stage_v;
      d.stage_v = 1'b0;
      // read masking lags the mask pins by two link clocks
      d.msk[0] = s_dqm;
      for (int i = 1; i < `SBI_DM_LAT; i++)
      begin
        d.msk[i] = q.msk[i-1];
      end
      if (is_rd || is_wr)
      begin
        // running burst is cut off on this edge
        if (q.st == SBI_READ && q.ap)
        begin
          pre_go[q.bank] = 1'b1;
        end
        if (q.st == SBI_WRITE && q.ap)
        begin
          wr_go[q.bank] = 1'b1;
        end
        if (is_wr && q.st == SBI_READ)
        begin
          // write kills unsent read words; mask keeps the bus quiet meanwhile
          d.pipe_v = '0;
          d.stage_v = 1'b0;
        end
        // write burst ends here: last word was taken one edge earlier
        d.st = is_rd ? SBI_READ : SBI_WRITE;
        d.bank = s_ba;
        d.col = s_addr[`SBI_COL_W-1:0];
        d.rem = `SBI_BURST_LEN - 3'h1;
        d.ap = s_addr[`SBI_AP_BIT];
        if (s_addr[`SBI_AP_BIT])
        begin
          busy_set[s_ba] = 1'b1;
        end
        if (is_rd)
        begin
          // words already in flight drain first, new data CAS later
          d.rd_req = 1'b1;
          d.rd_bank = s_ba;
          d.rd_col = s_addr[`SBI_COL_W-1:0];
        end
        else
        begin
          d.wr_valid = 1'b1;
          d.wr_bank = s_ba;
          d.wr_col = s_addr[`SBI_COL_W-1:0];
          d.wr_data = s_dq;
          d.wr_mask = s_dqm;
        end
      end
      else if (q.st != SBI_IDLE && is_pre && s_ba == q.bank)
      begin
        // same-bank precharge truncates the burst
        d.st = SBI_IDLE;
      end
      else if (q.st != SBI_IDLE && q.rem != 3'h0)
      begin
        // nop, active or precharge elsewhere: burst runs on
        d.col = q.col + `SBI_COL_W'(1);
        d.rem = q.rem - 3'h1;
        if (q.st == SBI_READ)
        begin
          d.rd_req = 1'b1;
          d.rd_bank = q.bank;
          d.rd_col = q.col + `SBI_COL_W'(1);
        end
        else
        begin
          d.wr_valid = 1'b1;
          d.wr_bank = q.bank;
          d.wr_col = q.col + `SBI_COL_W'(1);
          d.wr_data = s_dq;
          d.wr_mask = s_dqm;
        end
      end
      else if (q.st != SBI_IDLE)
      begin
        // natural end of burst
        d.st = SBI_IDLE;
        if (q.ap && q.st == SBI_READ)
        begin
          pre_go[q.bank] = 1'b1;
        end
        if (q.ap && q.st == SBI_WRITE)
        begin
          wr_go[q.bank] = 1'b1;
        end
      end
      if (is_pre)
      begin
        pre_go[s_ba] = 1'b1;
        busy_set[s_ba] = 1'b1;
      end
      // lanes load the word entering the last stage: data shows CAS link clocks after its read
      d.dq_o = d.pipe[`SBI_CAS_LAT-1];
      for (int b = 0; b < `SBI_DM_W; b++)
      begin
        d.dq_oe[b] = d.pipe_v[`SBI_CAS_LAT-1] & ~q.msk[`SBI_DM_LAT-1][b];
      end
    end
    // per-bank recovery and precharge timers
    for (int b = 0; b < `SBI_BANKS; b++)
    begin
      if (q.wr_cnt[b] != '0)
      begin
        d.wr_cnt[b] = q.wr_cnt[b] - `SBI_CNT_W'(1);
        if (q.wr_cnt[b] == `SBI_CNT_W'(1))
        begin
          pre_go[b] = 1'b1;
        end
      end
      if (wr_go[b])
      begin
        d.wr_cnt[b] = `SBI_CNT_W'(`SBI_WR_CYC);
      end
      if (q.rp_cnt[b] != '0)
      begin
        d.rp_cnt[b] = q.rp_cnt[b] - `SBI_CNT_W'(1);
        if (q.rp_cnt[b] == `SBI_CNT_W'(1))
        begin
          d.busy[b] = 1'b0;
        end
      end
      // a new access wins over a period ending in the same cycle
      if (busy_set[b])
      begin
        d.busy[b] = 1'b1;
      end
      if (pre_go[b])
      begin
        // a new precharge restarts the period, busy held throughout
        d.pre_start[b] = 1'b1;
        d.rp_cnt[b] = `SBI_CNT_W'(`SBI_RP_CYC);
        d.busy[b] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.st <= SBI_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign dq_o = q.dq_o;
  assign dq_oe = q.dq_oe;
  assign wr_valid = q.wr_valid;
  assign wr_bank = q.wr_bank;
  assign wr_col = q.wr_col;
  assign wr_data = q.wr_data;
  assign wr_mask = q.wr_mask;
  assign rd_req = q.rd_req;
  assign rd_bank = q.rd_bank;
  assign rd_col = q.rd_col;
  assign pre_start = q.pre_start;
  assign bank_busy = q.busy;

endmodule
`default_nettype wire

// *** logic/sbi_cfg.svh ***
// constants for the cross-bank burst interrupt engine
`ifndef SBI_CFG_SVH
`define SBI_CFG_SVH
`define SBI_BANKS 4
`define SBI_BA_W 2
`define SBI_ADDR_W 13
`define SBI_COL_W 9
`define SBI_AP_BIT 10
`define SBI_DQ_W 32
`define SBI_DM_W 4
`define SBI_BURST_LEN 3'h4
`define SBI_CAS_LAT 2
`define SBI_DM_LAT 2
`define SBI_PIN_W 56
`define SBI_CNT_W 8
`define SBI_CLK_NS 25
`define SBI_WR_NS 15
`define SBI_RP_NS 18
`define SBI_WR_CYC ((`SBI_WR_NS + `SBI_CLK_NS - 1) / `SBI_CLK_NS)
`define SBI_RP_CYC ((`SBI_RP_NS + `SBI_CLK_NS - 1) / `SBI_CLK_NS)
`endif

// *** logic/sbi_pkg.sv ***
// types of the cross-bank burst interrupt engine
`default_nettype none
`include "sbi_cfg.svh"
package sbi_pkg;
  // burst engine state, one-hot
  typedef enum logic [2:0] {
    SBI_IDLE = 3'b001,
    SBI_READ = 3'b010,
    SBI_WRITE = 3'b100
  } sbi_burst_t;

  // whole module state
  typedef struct packed {
    logic [`SBI_PIN_W-1:0] pin_s1;
    logic [`SBI_PIN_W-1:0] pin_s2;
    logic lclk_prev;
    sbi_burst_t st;
    logic [`SBI_BA_W-1:0] bank;
    logic [`SBI_COL_W-1:0] col;
    logic [2:0] rem;
    logic ap;
    logic rd_pend;
    logic stage_v;
    logic [`SBI_DQ_W-1:0] stage;
    logic [`SBI_CAS_LAT-1:0] pipe_v;
    logic [`SBI_CAS_LAT-1:0][`SBI_DQ_W-1:0] pipe;
    logic [`SBI_DM_LAT-1:0][`SBI_DM_W-1:0] msk;
    logic [`SBI_BANKS-1:0][`SBI_CNT_W-1:0] wr_cnt;
    logic [`SBI_BANKS-1:0][`SBI_CNT_W-1:0] rp_cnt;
    logic [`SBI_BANKS-1:0] busy;
    logic [`SBI_BANKS-1:0] pre_start;
    logic [`SBI_DQ_W-1:0] dq_o;
    logic [`SBI_DM_W-1:0] dq_oe;
    logic wr_valid;
    logic [`SBI_BA_W-1:0] wr_bank;
    logic [`SBI_COL_W-1:0] wr_col;
    logic [`SBI_DQ_W-1:0] wr_data;
    logic [`SBI_DM_W-1:0] wr_mask;
    logic rd_req;
    logic [`SBI_BA_W-1:0] rd_bank;
    logic [`SBI_COL_W-1:0] rd_col;
  } sbi_state_t;
endpackage
`default_nettype wire

// *** tb/sbi_burst_ctl_sva.sv ***
// checker for the burst engine ports
`timescale 1ns/1ps
`default_nettype none
module sbi_burst_ctl_chk
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic wr_valid,
  input wire logic [1:0] wr_bank,
  input wire logic [8:0] wr_col,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_mask,
  input wire logic rd_req,
  input wire logic [3:0] pre_start,
  input wire logic [3:0] bank_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_wr_pulse: assert property (wr_valid |=> !wr_valid) else $error("write beat longer than one cycle");
  a_rd_pulse: assert property (rd_req |=> !rd_req) else $error("read request longer than one cycle");
  a_pre_pulse: assert property ((pre_start & $past(pre_start)) == 4'h0) else $error("precharge pulse too long");
  a_pre_busy: assert property ((pre_start & ~bank_busy) == 4'h0) else $error("precharge on idle bank");
  a_busy_end: assert property ($fell(bank_busy[0]) |-> $past(pre_start[0]) || $past(pre_start[0], 2))
    else $error("bank0 idle without precharge");
  a_one_cmd: assert property (!(wr_valid && rd_req)) else $error("read and write on one edge");
  a_wr_hold: assert property (!wr_valid |-> $stable({wr_bank, wr_col, wr_data, wr_mask}))
    else $error("write fields moved");
  a_link_edge: assert property ((wr_valid || rd_req) |-> $past(link_clk, 2)) else $error("beat off link edge");
  c_pre: cover property (|pre_start);
  c_rd: cover property (rd_req);
  c_idle: cover property ($fell(bank_busy[1]));
endmodule
`default_nettype wire

// *** tb/sbi_ctl_model.sv ***
// controller model: issues commands and runs the link clock
`timescale 1ns/1ps
`default_nettype none
module sbi_ctl_model
(
  input wire logic clock,
  output logic link_clk,
  output logic [3:0] cmd_n,
  output logic [1:0] ba,
  output logic [12:0] addr,
  output logic [3:0] dqm,
  output logic [31:0] dq
);
  // link idles low between frames
  initial
  begin
    link_clk = 1'b0;
    cmd_n = 4'hf;
    ba = 2'h0;
    addr = 13'h0000;
    dqm = 4'h0;
    dq = 32'h0;
  end
  // one command per 8-cycle link period; pins move while link is low
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic [3:0] m);
    @(posedge clock);
    cmd_n <= c;
    ba <= b;
    addr <= a;
    dqm <= m;
    dq <= ~dq ^ {8{c}}; // data changes every beat, never stale
    repeat (3) @(posedge clock);
    link_clk <= 1'b1;
    repeat (4) @(posedge clock);
    link_clk <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// bench top: cross-bank burst interrupt scenarios
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [3:0] RD = 4'h5, WR = 4'h4, NP = 4'h7, AC = 4'h3; // cs ras cas we, low active
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic link_clk;
  logic [3:0] cmd_n, dqm, dq_oe, wr_mask, pre_start, bank_busy, pseen;
  logic [1:0] ba, wr_bank, rd_bank;
  logic [12:0] addr;
  logic [31:0] m_dq, dq_o, wr_data, lastr, firstr, d1;
  logic [31:0] rd_data = 32'h0;
  logic [31:0] lastw [4];
  logic [8:0] wr_col, rd_col;
  logic wr_valid, rd_req;
  int nw [4], nr [4], nv;
  int err_count = 0;
  int tests_run = 0;
  always #12.5 clock = ~clock;
  sbi_ctl_model m (.clock, .link_clk, .cmd_n, .ba, .addr, .dqm, .dq(m_dq));
  sbi_burst_ctl dut (.clock, .arst_n, .link_clk, .cs_n(cmd_n[3]), .ras_n(cmd_n[2]), .cas_n(cmd_n[1]),
    .we_n(cmd_n[0]), .ba, .addr, .dqm, .dq_i((|dq_oe) ? dq_o : m_dq), .rd_data, .dq_o, .dq_oe, .wr_valid,
    .wr_bank, .wr_col, .wr_data, .wr_mask, .rd_req, .rd_bank, .rd_col, .pre_start, .bank_busy);
  // array model and beat monitor; array word encodes bank and column
  always @(posedge clock)
  begin
    rd_data <= {21'h0, rd_bank, rd_col};
    if (wr_valid === 1'b1)
    begin
      nw[wr_bank]++;
      lastw[wr_bank] = wr_data;
    end
    if (rd_req === 1'b1)
      nr[rd_bank]++;
    if (|dq_oe)
    begin
      if (nv == 0)
        firstr = dq_o;
      lastr = dq_o;
      nv++;
    end
    pseen = pseen | pre_start;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // two commands back to back, then NOPs until all bursts and timers end
  task automatic pair(input logic [3:0] c1, input logic [1:0] b1, input logic [12:0] a1, input logic [3:0] c2,
    input logic [1:0] b2, input logic [12:0] a2);
    nw = '{0, 0, 0, 0};
    nr = '{0, 0, 0, 0};
    pseen = 4'h0;
    nv = 0;
    m.issue(NP, 2'h0, 13'h0, (c2 == WR) ? 4'hf : 4'h0);
    m.issue(c1, b1, a1, 4'h0);
    d1 = m_dq;
    m.issue(c2, b2, a2, 4'hf);
    repeat (8) m.issue(NP, 2'h0, 13'h0, 4'h0);
  endtask
  task automatic t_wr_wr();
    pair(WR, 2'h0, 13'h010, WR, 2'h1, 13'h020);
    chk(nw[0], 1, "bank0 beats");
    chk(lastw[0], d1, "bank0 last word");
    chk(nw[1], 4, "bank1 beats");
    chk(wr_bank, 2'h1, "last write bank");
    chk(wr_col, 9'h023, "last write column");
    $display("test wr_wr done");
  endtask
  task automatic t_rd_wr();
    pair(RD, 2'h2, 13'h030, WR, 2'h3, 13'h040);
    chk(nr[2], 1, "bank2 reads");
    chk(nw[3], 4, "bank3 beats");
    chk(nv, 0, "read words on bus");
    $display("test rd_wr done");
  endtask
  task automatic t_rdap_rd();
    pair(RD, 2'h0, 13'h0410, RD, 2'h1, 13'h040);
    chk(pseen, 4'h1, "precharge banks");
    chk(nr[1], 4, "bank1 reads");
    chk(firstr, {21'h0, 2'h0, 9'h010}, "first read word");
    chk(lastr, {21'h0, 2'h1, 9'h043}, "last read word");
    $display("test rdap_rd done");
  endtask
  task automatic t_rdap_wr();
    pair(RD, 2'h2, 13'h0450, WR, 2'h3, 13'h060);
    chk(pseen, 4'h4, "precharge banks");
    chk(nr[2], 1, "bank2 reads");
    chk(nv, 0, "read words on bus");
    $display("test rdap_wr done");
  endtask
  task automatic t_wrap_rd();
    pair(WR, 2'h1, 13'h0470, RD, 2'h0, 13'h080);
    chk(pseen, 4'h2, "precharge banks");
    chk(nw[1], 1, "bank1 beats");
    chk(bank_busy, 4'h0, "banks idle");
    $display("test wrap_rd done");
  endtask
  task automatic t_wrap_wr();
    pair(WR, 2'h3, 13'h0490, WR, 2'h2, 13'h0a0);
    chk(pseen, 4'h8, "precharge banks");
    chk(nw[3], 1, "bank3 beats");
    $display("test wrap_wr done");
  endtask
  task automatic t_active();
    chk(bank_busy, 4'h0, "banks idle before active");
    pair(WR, 2'h0, 13'h0b0, AC, 2'h1, 13'h0);
    chk(nw[0], 4, "bank0 beats");
    chk(wr_col, 9'h0b3, "last write column");
    chk(wr_mask, 4'h0, "last write mask");
    $display("test active done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog: whole sequence needs about 16 us
  initial
  begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_wr_wr();
    t_rd_wr();
    t_rdap_rd();
    t_rdap_wr();
    t_wrap_rd();
    t_wrap_wr();
    t_active();
    report_and_stop();
  end
endmodule
bind sbi_burst_ctl sbi_burst_ctl_chk chk (.clock, .arst_n, .link_clk, .wr_valid, .wr_bank, .wr_col, .wr_data,
  .wr_mask, .rd_req, .pre_start, .bank_busy);
`default_nettype wire
